//--- verilog/wra_map.vh
`ifndef WRA_MAP_VH
`define WRA_MAP_VH
`define WRA_ADDR_PTR_FIRST    8'hd6
`define WRA_ADDR_PTR_SECOND   8'hd7
`define WRA_ADDR_FLAGS        8'hd5
`define WRA_ADDR_SP           8'hd9
`define WRA_ADDR_SEQ_STATUS   8'hd8
`define WRA_RST_PTR_FIRST     8'hc0
`define WRA_RST_PTR_SECOND    8'hc8
`define WRA_RST_SP            8'h00
`define WRA_RST_FLAGS         8'h00
`define WRA_WORK_NIBBLE       4'hc
`define WRA_SET1_BASE         8'hc0
`define WRA_OP_NONE           3'h0
`define WRA_OP_CALL           3'h1
`define WRA_OP_RET            3'h2
`define WRA_OP_INT            3'h3
`define WRA_OP_INTERRUPT_RETURN           3'h4
`define WRA_OP_PUSH           3'h5
`define WRA_OP_POP            3'h6
`endif

//--- verilog/wra_work_addr.v
`timescale 1ns/1ps
// working register address formation, 4-bit or 8-bit field
`include "wra_map.vh"
module wra_work_addr (
  input  wire [7:0] field_i,
  input  wire       long_field_i,
  input  wire [7:0] ptr_first_i,
  input  wire [7:0] ptr_second_i,
  output wire [7:0] addr_o,
  output wire       is_working_o
);
  wire       long_work = long_field_i && (field_i[7:4] == `WRA_WORK_NIBBLE);
  wire [7:0] ptr       = field_i[3] ? ptr_second_i : ptr_first_i;

  assign is_working_o = !long_field_i || long_work;
  assign addr_o       = is_working_o ? {ptr[7:3], field_i[2:0]} : field_i;
endmodule // wra_work_addr

//--- verilog/wra_stack_step.v
`timescale 1ns/1ps
// stack pointer step: pre-decrement for push, post-increment for pop
module wra_stack_step (
  input  wire [7:0] sp_i,
  input  wire       push_i,
  input  wire       pop_i,
  output wire [7:0] addr_o,
  output wire [7:0] next_sp_o
);
  wire [7:0] dec = sp_i - 8'h01;
  wire [7:0] inc = sp_i + 8'h01;

  assign addr_o    = push_i ? dec : sp_i;
  assign next_sp_o = push_i ? dec : (pop_i ? inc : sp_i);
endmodule // wra_stack_step

//--- verilog/wra_core.v
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "wra_map.vh"
// Operation
// - a 16-bit pair access forces an even base, high byte at the even address and low byte at the odd one.
// - direct register addressing reaches every location except the duplicated upper set 2 area.
// - after reset the first pointer selects C0H-C7H and the second selects C8H-CFH.
// - the top bit of a 4-bit working field chooses the first pointer on 0 and the second on 1.
// - a working address is the chosen pointer's upper five bits joined to the field's lower three bits.
// - an 8-bit field whose upper nibble is 1100B is treated as a 4-bit working reference.
// - in 8-bit working addressing bit 3 of the field selects the pointer.
// - a call pushes the program counter and a return pops it back.
// - interrupt entry pushes program counter and flags, interrupt return pops both back.
// - the stack pointer drops by one before each pushed byte and rises by one after each popped byte.
// - the 8-bit stack pointer lives at D9H, and software loads it before using the stack.
// - four user-stack push and pop operations keep stacks anywhere in the register file.
// - the two working pointers are registers at D6H and D7H that software may load.
// - set 2 is reached only by indirect or indexed access, set 1 by direct access.
module wra_core (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        clk_en_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  // operand address request
  input  wire        opnd_req_i,
  input  wire [7:0]  opnd_field_i,
  input  wire        opnd_long_i,
  input  wire [1:0]  opnd_mode_i,
  input  wire        opnd_pair_i,
  output reg         opnd_valid_o,
  output reg  [7:0]  opnd_addr_o,
  output reg  [7:0]  opnd_addr_lo_o,
  output reg         opnd_set2_o,
  output reg         opnd_invalid_o,
  // stack sequencing
  input  wire [2:0]  stk_op_i,
  input  wire [15:0] stk_pc_i,
  input  wire [7:0]  stk_flags_i,
  input  wire [7:0]  stk_rdata_i,
  output reg         stk_busy_o,
  output reg         stk_we_o,
  output reg         stk_re_o,
  output reg  [7:0]  stk_addr_o,
  output reg  [7:0]  stk_wdata_o,
  output reg         stk_done_o,
  output reg  [15:0] stk_pc_o,
  output reg  [7:0]  stk_flags_o,
  output reg         stk_pc_load_o,
  output reg         stk_flags_load_o,
  // user stack: pointer is a register file byte supplied by execution unit
  input  wire        ustk_req_i,
  input  wire [1:0]  ustk_kind_i,
  input  wire [7:0]  ustk_ptr_i,
  output reg  [7:0]  ustk_addr_o,
  output reg  [7:0]  ustk_next_ptr_o,
  output reg         ustk_valid_o,
  output reg  [7:0]  ptr_first_o,
  output reg  [7:0]  ptr_second_o
);
  localparam MODE_DIRECT = 2'h0;
  localparam MODE_WORK   = 2'h1;
  localparam MODE_IND    = 2'h2;
  localparam MODE_IDX    = 2'h3;

  localparam S_IDLE  = 3'h0;
  localparam S_PUSH  = 3'h1;
  localparam S_POPRD = 3'h2;
  localparam S_POPWT = 3'h3;
  localparam S_DONE  = 3'h4;

  reg  [7:0]  ptr_first;
  reg  [7:0]  ptr_second;
  reg  [7:0]  sp;
  reg  [2:0]  state;
  reg  [2:0]  cur_op;
  reg  [1:0]  cnt;
  reg  [1:0]  total;
  reg  [31:0] shift;
  reg  [23:0] gather;
  wire [7:0]  work_addr;
  wire        is_work;
  wire [7:0]  step_addr;
  wire [7:0]  next_sp;
  wire        do_push = (state == S_PUSH);
  wire        do_pop  = (state == S_POPRD);
  wire        sp_written = reg_wr_i && (reg_addr_i == `WRA_ADDR_SP);

  function in_set1;
    input [7:0] a;
    in_set1 = (a >= `WRA_SET1_BASE);
  endfunction

  function [1:0] op_bytes;
    input [2:0] op;
    case (op)
      `WRA_OP_CALL, `WRA_OP_RET: op_bytes = 2'h2;
      `WRA_OP_INT, `WRA_OP_INTERRUPT_RETURN: op_bytes = 2'h3;
      `WRA_OP_PUSH, `WRA_OP_POP: op_bytes = 2'h1;
      default:                   op_bytes = 2'h0;
    endcase
  endfunction

  wra_work_addr u_work (
    .field_i      (opnd_field_i),
    .long_field_i (opnd_long_i),
    .ptr_first_i  (ptr_first),
    .ptr_second_i (ptr_second),
    .addr_o       (work_addr),
    .is_working_o (is_work)
  );

  wra_stack_step u_step (
    .sp_i      (sp),
    .push_i    (do_push),
    .pop_i     (do_pop),
    .addr_o    (step_addr),
    .next_sp_o (next_sp)
  );

  // register port and pointers
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_first   <= `WRA_RST_PTR_FIRST;
      ptr_second  <= `WRA_RST_PTR_SECOND;
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      if (reg_wr_i && reg_addr_i == `WRA_ADDR_PTR_FIRST) begin
        ptr_first <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `WRA_ADDR_PTR_SECOND) begin
        ptr_second <= reg_wdata_i;
      end
      if (reg_rd_i) begin
        case (reg_addr_i)
          `WRA_ADDR_PTR_FIRST:  reg_rdata_o <= ptr_first;
          `WRA_ADDR_PTR_SECOND: reg_rdata_o <= ptr_second;
          `WRA_ADDR_SP:         reg_rdata_o <= sp;
          `WRA_ADDR_SEQ_STATUS: reg_rdata_o <= {5'h00, state};
          default:              reg_rdata_o <= 8'h00;
        endcase
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // operand address formation
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      opnd_valid_o   <= 1'b0;
      opnd_addr_o    <= 8'h00;
      opnd_addr_lo_o <= 8'h00;
      opnd_set2_o    <= 1'b0;
      opnd_invalid_o <= 1'b0;
    end else if (clk_en_i) begin
      opnd_valid_o <= opnd_req_i;
      if (opnd_req_i) begin
        case (opnd_mode_i)
          MODE_WORK: begin
            opnd_addr_o    <= {work_addr[7:1], work_addr[0] & ~opnd_pair_i};
            opnd_addr_lo_o <= {work_addr[7:1], 1'b1};
            opnd_set2_o    <= 1'b0;
            opnd_invalid_o <= !is_work;
          end
          MODE_DIRECT: begin
            // long field with 1100B is a working reference
            opnd_addr_o    <= is_work ? {work_addr[7:1], work_addr[0] & ~opnd_pair_i}
                                      : {opnd_field_i[7:1], opnd_field_i[0] & ~opnd_pair_i};
            opnd_addr_lo_o <= is_work ? {work_addr[7:1], 1'b1} : {opnd_field_i[7:1], 1'b1};
            opnd_set2_o    <= 1'b0;
            opnd_invalid_o <= !opnd_long_i;
          end
          default: begin
            // indirect and indexed reach set 2 in the upper range
            opnd_addr_o    <= {opnd_field_i[7:1], opnd_field_i[0] & ~opnd_pair_i};
            opnd_addr_lo_o <= {opnd_field_i[7:1], 1'b1};
            opnd_set2_o    <= in_set1(opnd_field_i);
            opnd_invalid_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // stack sequencer: one byte per cycle on push, one byte per two cycles on pop, sp writes by software win only when idle
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sp               <= `WRA_RST_SP;
      state            <= S_IDLE;
      cur_op           <= `WRA_OP_NONE;
      cnt              <= 2'h0;
      total            <= 2'h0;
      shift            <= 32'h0;
      gather           <= 24'h0;
      stk_busy_o       <= 1'b0;
      stk_we_o         <= 1'b0;
      stk_re_o         <= 1'b0;
      stk_addr_o       <= 8'h00;
      stk_wdata_o      <= 8'h00;
      stk_done_o       <= 1'b0;
      stk_pc_o         <= 16'h0000;
      stk_flags_o      <= `WRA_RST_FLAGS;
      stk_pc_load_o    <= 1'b0;
      stk_flags_load_o <= 1'b0;
    end else if (clk_en_i) begin
      stk_we_o         <= 1'b0;
      stk_re_o         <= 1'b0;
      stk_done_o       <= 1'b0;
      stk_pc_load_o    <= 1'b0;
      stk_flags_load_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (sp_written) begin
            sp <= reg_wdata_i;
          end else if (op_bytes(stk_op_i) != 2'h0) begin
            cur_op     <= stk_op_i;
            total      <= op_bytes(stk_op_i);
            cnt        <= 2'h0;
            stk_busy_o <= 1'b1;
            // push order: pc low, pc high, then flags so pops come back reversed
            shift <= {stk_pc_i[7:0], stk_pc_i[15:8], stk_flags_i, 8'h00};
            if (stk_op_i == `WRA_OP_PUSH) begin
              shift <= {stk_flags_i, 24'h0};
            end
            if (stk_op_i == `WRA_OP_CALL || stk_op_i == `WRA_OP_INT || stk_op_i == `WRA_OP_PUSH) begin
              state <= S_PUSH;
            end else begin
              state <= S_POPRD;
            end
          end
        end
        S_PUSH: begin
          stk_we_o    <= 1'b1;
          stk_addr_o  <= step_addr;
          stk_wdata_o <= shift[31:24];
          sp          <= next_sp;
          shift       <= {shift[23:0], 8'h00};
          cnt         <= cnt + 2'h1;
          if (cnt + 2'h1 == total) begin
            state <= S_DONE;
          end
        end
        S_POPRD: begin
          stk_re_o   <= 1'b1;
          stk_addr_o <= step_addr;
          sp         <= next_sp;
          state      <= S_POPWT;
        end
        S_POPWT: begin
          // memory answers in the cycle that the read strobe stands
          gather <= {gather[15:0], stk_rdata_i};
          cnt    <= cnt + 2'h1;
          state  <= (cnt + 2'h1 == total) ? S_DONE : S_POPRD;
        end
        S_DONE: begin
          stk_busy_o <= 1'b0;
          stk_done_o <= 1'b1;
          state      <= S_IDLE;
          case (cur_op)
            `WRA_OP_RET: begin
              stk_pc_o      <= gather[15:0];
              stk_pc_load_o <= 1'b1;
            end
            `WRA_OP_INTERRUPT_RETURN: begin
              stk_flags_o      <= gather[23:16];
              stk_pc_o         <= gather[15:0];
              stk_flags_load_o <= 1'b1;
              stk_pc_load_o    <= 1'b1;
            end
            `WRA_OP_POP: begin
              stk_flags_o <= gather[7:0];
            end
            default: begin
              stk_pc_o <= stk_pc_o;
            end
          endcase
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // user stacks: variant a pushes up / pops down, variant b the mirror
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ustk_addr_o     <= 8'h00;
      ustk_next_ptr_o <= 8'h00;
      ustk_valid_o    <= 1'b0;
      ptr_first_o     <= `WRA_RST_PTR_FIRST;
      ptr_second_o    <= `WRA_RST_PTR_SECOND;
    end else if (clk_en_i) begin
      ustk_valid_o <= ustk_req_i;
      ptr_first_o  <= ptr_first;
      ptr_second_o <= ptr_second;
      if (ustk_req_i) begin
        case (ustk_kind_i)
          2'h0: begin
            ustk_addr_o     <= ustk_ptr_i + 8'h01;
            ustk_next_ptr_o <= ustk_ptr_i + 8'h01;
          end
          2'h1: begin
            ustk_addr_o     <= ustk_ptr_i - 8'h01;
            ustk_next_ptr_o <= ustk_ptr_i - 8'h01;
          end
          2'h2: begin
            ustk_addr_o     <= ustk_ptr_i;
            ustk_next_ptr_o <= ustk_ptr_i - 8'h01;
          end
          default: begin
            ustk_addr_o     <= ustk_ptr_i;
            ustk_next_ptr_o <= ustk_ptr_i + 8'h01;
          end
        endcase
      end
    end
  end
endmodule // wra_core

//--- verification/wra_core_monitor.sv
`timescale 1ns/1ps
module wra_core_monitor (
  input        clk_i,
  input        reset_n_i,
  input        opnd_req_i,
  input  [7:0] opnd_field_i,
  input        opnd_long_i,
  input  [1:0] opnd_mode_i,
  input        opnd_pair_i,
  input        opnd_valid_o,
  input  [7:0] opnd_addr_o,
  input  [7:0] opnd_addr_lo_o,
  input  [2:0] stk_op_i,
  input [15:0] stk_pc_i,
  input  [7:0] stk_flags_i,
  input        stk_busy_o,
  input        stk_we_o,
  input        stk_re_o,
  input  [7:0] stk_addr_o,
  input  [7:0] stk_wdata_o,
  input        stk_done_o,
  input  [7:0] ptr_first_o,
  input  [7:0] ptr_second_o
);
  // clk_en_i drops only while no request or stack op is pending, so it is left out of the antecedents
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_pair_even: assert property (
    opnd_req_i && opnd_pair_i |=> opnd_valid_o && !opnd_addr_o[0] && opnd_addr_lo_o == (opnd_addr_o | 8'h01))
    else $error("pair base not even or low byte not next odd");
  a_work_short: assert property (
    opnd_req_i && opnd_mode_i == 2'h1 && !opnd_long_i && !opnd_pair_i |=> opnd_addr_o ==
    {($past(opnd_field_i[3]) ? ptr_second_o[7:3] : ptr_first_o[7:3]), $past(opnd_field_i[2:0])})
    else $error("short working address wrong");
  a_work_long: assert property (
    opnd_req_i && opnd_long_i && opnd_field_i[7:4] == 4'hc && !opnd_mode_i[1] && !opnd_pair_i |=> opnd_addr_o ==
    {($past(opnd_field_i[3]) ? ptr_second_o[7:3] : ptr_first_o[7:3]), $past(opnd_field_i[2:0])})
    else $error("long working address wrong");
  a_direct_pass: assert property (
    opnd_req_i && opnd_long_i && opnd_mode_i == 2'h0 && opnd_field_i[7:4] != 4'hc && !opnd_pair_i
    |=> opnd_addr_o == $past(opnd_field_i)) else $error("direct address altered");
  a_reset_ptrs: assert property (
    !$past(reset_n_i) |-> ptr_first_o == 8'hc0 && ptr_second_o == 8'hc8) else $error("pointer reset value wrong");
  a_push_step: assert property (
    stk_we_o && $past(stk_we_o) |-> stk_addr_o == $past(stk_addr_o) - 8'h01) else $error("push not pre-decrement");
  a_pop_step: assert property (
    stk_re_o && $past(stk_re_o, 2) |-> stk_addr_o == $past(stk_addr_o, 2) + 8'h01) else $error("pop not post-increment");
  a_call_frame: assert property (
    stk_op_i == 3'h1 && !stk_busy_o |-> ##2 stk_we_o && stk_wdata_o == $past(stk_pc_i[7:0], 2)
    ##1 stk_we_o && stk_wdata_o == $past(stk_pc_i[15:8], 3) ##1 stk_done_o) else $error("call frame wrong");
  a_int_frame: assert property (
    stk_op_i == 3'h3 && !stk_busy_o |-> ##2 stk_we_o [*3] ##0 stk_wdata_o == $past(stk_flags_i, 4)
    ##1 stk_done_o) else $error("interrupt frame wrong");
endmodule // wra_core_monitor
bind wra_core wra_core_monitor i_wra_core_monitor (.clk_i, .reset_n_i, .opnd_req_i, .opnd_field_i, .opnd_long_i,
  .opnd_mode_i, .opnd_pair_i, .opnd_valid_o, .opnd_addr_o, .opnd_addr_lo_o, .stk_op_i, .stk_pc_i, .stk_flags_i,
  .stk_busy_o, .stk_we_o, .stk_re_o, .stk_addr_o, .stk_wdata_o, .stk_done_o, .ptr_first_o, .ptr_second_o);

//--- verification/wra_core_tb_top.sv
`timescale 1ns/1ps
`include "wra_map.vh"
module wra_core_tb_top;
  reg         clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, opnd_req_i = 1'b0;
  reg         opnd_long_i = 1'b0, opnd_pair_i = 1'b0, ustk_req_i = 1'b0, clk_en_i = 1'b1;
  reg  [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, opnd_field_i = 8'h00, stk_flags_i = 8'h00;
  reg  [7:0]  ustk_ptr_i = 8'h00, p0m, p1m, e;
  reg  [1:0]  opnd_mode_i = 2'h0, ustk_kind_i = 2'h0;
  reg  [2:0]  stk_op_i = 3'h0;
  reg  [15:0] stk_pc_i = 16'h0000;
  wire [7:0]  reg_rdata_o, opnd_addr_o, opnd_addr_lo_o, stk_addr_o, stk_wdata_o, stk_flags_o;
  wire [7:0]  ustk_addr_o, ustk_next_ptr_o, ptr_first_o, ptr_second_o, stk_rdata_i;
  wire [15:0] stk_pc_o;
  wire        opnd_valid_o, stk_busy_o, stk_we_o, stk_re_o, stk_done_o, ustk_valid_o;
  wire        opnd_set2_o, opnd_invalid_o, stk_pc_load_o, stk_flags_load_o;
  integer     n_mismatch = 0, num_checks = 0, seed = 75928, cyc = 0, i, j;
  reg  [7:0]  mem [0:255];
  wra_core i_wra_core (.clk_i, .reset_n_i, .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .opnd_req_i, .opnd_field_i, .opnd_long_i, .opnd_mode_i, .opnd_pair_i, .opnd_valid_o,
    .opnd_addr_o, .opnd_addr_lo_o, .opnd_set2_o, .opnd_invalid_o, .stk_op_i, .stk_pc_i, .stk_flags_i,
    .stk_rdata_i, .stk_busy_o, .stk_we_o, .stk_re_o, .stk_addr_o, .stk_wdata_o, .stk_done_o, .stk_pc_o,
    .stk_flags_o, .stk_pc_load_o, .stk_flags_load_o, .ustk_req_i, .ustk_kind_i, .ustk_ptr_i, .ustk_addr_o,
    .ustk_next_ptr_o, .ustk_valid_o, .ptr_first_o, .ptr_second_o);
  initial forever #10 clk_i = ~clk_i;
  // stack memory: read data stand in the cycle of the read strobe, inverted garbage otherwise
  always @(posedge clk_i) begin
    if (stk_we_o) mem[stk_addr_o] <= stk_wdata_o;
  end
  assign stk_rdata_i = stk_re_o ? mem[stk_addr_o] : ~mem[stk_addr_o];
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] x);
    begin
      num_checks = num_checks + 1;
      if (g !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  function [7:0] wexp(input [3:0] f);
    wexp = {(f[3] ? p1m[7:3] : p0m[7:3]), f[2:0]};
  endfunction
  task bus(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= w;
      reg_rd_i <= !w;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1;
      if (!w) chk(reg_rdata_o, d);
    end
  endtask
  task opnd(input [7:0] f, input lg, input [1:0] m, input pr, input [7:0] x);
    begin
      @(posedge clk_i);
      opnd_req_i <= 1'b1;
      opnd_field_i <= f;
      opnd_long_i <= lg;
      opnd_mode_i <= m;
      opnd_pair_i <= pr;
      @(posedge clk_i);
      opnd_req_i <= 1'b0;
      #1;
      chk(opnd_valid_o, 1'b1);
      chk(opnd_addr_o, x);
      if (pr) chk(opnd_addr_lo_o, x | 8'h01);
      chk(opnd_set2_o, m[1] && f >= 8'hc0);
      chk(opnd_invalid_o, (m == 2'h0 && !lg) || (m == 2'h1 && lg && f[7:4] != 4'hc));
    end
  endtask
  task stk(input [2:0] op, input [1:0] ld);
    integer k;
    begin
      @(posedge clk_i);
      stk_op_i <= op;
      @(posedge clk_i);
      stk_op_i <= 3'h0;
      #1;
      chk(stk_busy_o, 1'b1);
      for (k = 0; k < 12 && stk_done_o !== 1'b1; k = k + 1) begin
        @(posedge clk_i);
        #1;
      end
      chk(stk_done_o, 1'b1);
      chk(stk_busy_o, 1'b0);
      chk({stk_pc_load_o, stk_flags_load_o}, ld);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    p0m = 8'hc0;
    p1m = 8'hc8;
    bus(1'b0, `WRA_ADDR_PTR_FIRST, p0m);
    bus(1'b0, `WRA_ADDR_PTR_SECOND, p1m);
    bus(1'b0, 8'h40, 8'h00);
    bus(1'b0, `WRA_ADDR_SEQ_STATUS, 8'h00);
    for (j = 0; j < 5; j = j + 1) begin
      for (i = 0; i < 16; i = i + 1) begin
        opnd({4'h0, i[3:0]}, 1'b0, 2'h1, 1'b0, wexp(i[3:0]));
        opnd({4'hc, i[3:0]}, 1'b1, 2'h1, 1'b0, wexp(i[3:0]));
        opnd({4'hc, i[3:0]}, 1'b1, 2'h0, 1'b1, wexp(i[3:0]) & 8'hfe);
        e = $random(seed) & 8'hbf;
        opnd(e, 1'b1, 2'h0, 1'b0, e);
        opnd(e, 1'b1, 2'h1, 1'b0, e);
        e = $random(seed);
        opnd(e, 1'b1, {1'b1, e[0]}, e[1], {e[7:1], e[0] & ~e[1]});
      end
      p0m = $random(seed);
      p1m = $random(seed);
      bus(1'b1, `WRA_ADDR_PTR_FIRST, p0m);
      bus(1'b1, `WRA_ADDR_PTR_SECOND, p1m);
      bus(1'b0, `WRA_ADDR_PTR_FIRST, p0m);
      bus(1'b0, `WRA_ADDR_PTR_SECOND, p1m);
    end
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    bus(1'b0, `WRA_ADDR_PTR_FIRST, 8'hc0);
    bus(1'b0, `WRA_ADDR_PTR_SECOND, 8'hc8);
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    bus(1'b1, `WRA_ADDR_PTR_FIRST, 8'h3a);
    @(posedge clk_i);
    clk_en_i <= 1'b1;
    bus(1'b0, `WRA_ADDR_PTR_FIRST, 8'hc0);
    bus(1'b1, `WRA_ADDR_SP, 8'hff);
    bus(1'b0, `WRA_ADDR_SP, 8'hff);
    stk_pc_i <= $random(seed);
    stk(`WRA_OP_CALL, 2'h0);
    chk({mem[8'hfd], mem[8'hfe]}, stk_pc_i);
    bus(1'b0, `WRA_ADDR_SP, 8'hfd);
    stk(`WRA_OP_RET, 2'h2);
    chk(stk_pc_o, stk_pc_i);
    bus(1'b0, `WRA_ADDR_SP, 8'hff);
    stk_pc_i <= $random(seed);
    stk_flags_i <= $random(seed);
    stk(`WRA_OP_INT, 2'h0);
    chk({mem[8'hfc], mem[8'hfd]}, {stk_flags_i, stk_pc_i[15:8]});
    bus(1'b0, `WRA_ADDR_SP, 8'hfc);
    stk(`WRA_OP_INTERRUPT_RETURN, 2'h3);
    chk(stk_pc_o, stk_pc_i);
    chk(stk_flags_o, stk_flags_i);
    bus(1'b0, `WRA_ADDR_SP, 8'hff);
    stk_flags_i <= $random(seed);
    stk(`WRA_OP_PUSH, 2'h0);
    chk(mem[8'hfe], stk_flags_i);
    bus(1'b0, `WRA_ADDR_SP, 8'hfe);
    stk(`WRA_OP_POP, 2'h0);
    chk(stk_flags_o, stk_flags_i);
    bus(1'b0, `WRA_ADDR_SP, 8'hff);
    for (j = 0; j < 4; j = j + 1) begin
      @(posedge clk_i);
      ustk_req_i <= 1'b1;
      ustk_kind_i <= j[1:0];
      ustk_ptr_i <= $random(seed);
      @(posedge clk_i);
      ustk_req_i <= 1'b0;
      #1;
      e = (j[0] ^ j[1]) ? ustk_ptr_i - 8'h01 : ustk_ptr_i + 8'h01;
      chk(ustk_valid_o, 1'b1);
      chk(ustk_next_ptr_o, e);
      chk(ustk_addr_o, j[1] ? ustk_ptr_i : e);
    end
    report_and_stop;
  end
endmodule // wra_core_tb_top
